// ===== core/scb_consts.svh
/*
 Offsets, field positions, limits and reset values of the sample capture
 buffer control. Assumes a 32-bit APB register bus and 100 MHz clock.
*/
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH

// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define SCB_OFS_CTRL       8'h00
`define SCB_OFS_LEN        8'h04
`define SCB_OFS_CFG        8'h08
`define SCB_OFS_RATE       8'h0C
`define SCB_OFS_STAT       8'h10
`define SCB_OFS_BYTES      8'h14
`define SCB_OFS_RATEMAX    8'h18

// ***********************************************************************
// Control word fields
// ***********************************************************************
`define SCB_CTRL_START     0
`define SCB_CTRL_STOP      1
`define SCB_CTRL_ACQ       2
`define SCB_CTRL_MODE_LO   3
`define SCB_CTRL_MODE_HI   4

// ***********************************************************************
// Field codes, limits, reset values
// ***********************************************************************
`define SCB_ACQ_SINGLE     1'h0
`define SCB_ACQ_WRAP       1'h1
`define SCB_MODE_IMMEDIATE 2'h0
`define SCB_MODE_EDGE      2'h1
`define SCB_MODE_PER_EDGE  2'h2
`define SCB_MODE_LAST      2'h2
`define SCB_LEN_MAX        13'h1000
`define SCB_LEN_RST        13'h0020
`define SCB_RATE_EXP_MAX   5'h14
`define SCB_CFG_RST        2'h0
`define SCB_BLOCK_LAST     9'h1FF
`define SCB_WORD_BYTES     23'h000004
`define SCB_BLOCK_BYTES    23'h000800

`endif

// ===== core/scb_pkg.sv
/*
 Types of the sample capture buffer control.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package scb_pkg;
	// Capture sequencer states
	typedef enum logic [2:0] {
		SCB_IDLE,
		SCB_ARMED,
		SCB_RUN,
		SCB_FILL,
		SCB_DONE
	} scb_state_e;
	typedef logic [31:0] scb_word_t;
endpackage

// ===== core/scb_trig_sync.sv
/*
 Synchroniser and falling edge detector for the external trigger.
 Assumes an asynchronous active-low trigger pin, idle high.
*/
`timescale 1ns/1ps
module scb_trig_sync (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic trigInN,
	output logic      fallPulse
);
	logic metaReg;
	logic syncReg;
	logic prevReg;

	// Two flops, then one-cycle pulse on high-to-low only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			metaReg   <= 1'b1;
			syncReg   <= 1'b1;
			prevReg   <= 1'b1;
			fallPulse <= 1'b0;
		end else begin
			metaReg   <= trigInN;
			syncReg   <= metaReg;
			prevReg   <= syncReg;
			fallPulse <= prevReg && !syncReg;
		end
	end
endmodule

// ===== core/scb_sample_mem.sv
/*
 Capture buffer word memory, one write port and one registered read port.
 Assumes writer and reader share one clock.
*/
`timescale 1ns/1ps
module scb_sample_mem #(
	parameter int AW = 20,
	parameter int DW = 32
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Word store; byte 0 of a sample sits in bits 7:0
	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read port
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// ===== core/scb_capture_ctrl.sv
/*
 Sample capture buffer control: APB registers, capture sequencer,
 rate divider, zero fill, byte count and state word.
 Assumes the datapath gives a one-cycle maxRateTick at the maximum
 capture rate and holds the four sample words stable on the clock.
*/
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "scb_consts.svh"
module scb_capture_ctrl #(
	parameter int AW = 20
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          maxRateTick,
	input  wire logic [31:0]   maxSampleRateHz,
	input  wire logic [31:0]   sampleX,
	input  wire logic [31:0]   sampleY,
	input  wire logic [31:0]   sampleR,
	input  wire logic [31:0]   sampleTheta,
	input  wire logic          externalTriggerInputN,
	input  wire logic [AW-1:0] bufRdAddr,
	output logic      [31:0]   bufRdData
);
	// ***************************************************************
	// Declarations
	// ***************************************************************
	scb_pkg::scb_state_e state_reg;
	logic [12:0]         lenKb_reg;
	logic [1:0]          cfg_reg;
	logic [4:0]          rateExp_reg;
	logic                acq_reg;
	logic [1:0]          mode_reg;
	logic                triggered_reg;
	logic                wrapped_reg;
	logic                stopPend_reg;
	logic [AW-1:0]       wrAddr_reg;
	logic [22:0]         byteCount_reg;
	logic [2:0]          wordsLeft_reg;
	logic [1:0]          subIdx_reg;
	logic [20:0]         divCnt_reg;
	scb_pkg::scb_word_t  smp_reg [4];
	scb_pkg::scb_word_t  smpIn [4];
	logic                trigFall;
	logic                apbSetup;
	logic                apbOk;
	logic                addrOk;
	logic                slvErr;
	logic [31:0]         rdMux;
	logic [12:0]         lenClamp;
	logic [12:0]         lenNew;
	logic [4:0]          rateNew;
	logic                startCmd;
	logic                stopCmd;
	logic                lenWr;
	logic                cfgWr;
	logic                cfgReset;
	logic                inProg;
	logic [20:0]         lastAddr;
	logic                atLast;
	logic                memWe;
	logic                realWr;
	logic [31:0]         memData;
	logic [20:0]         divMask;
	logic                divTick;
	logic                sampleEvt;
	logic                trigStopEvt;
	logic                stopReq;
	logic                finishing;
	logic                accept;
	logic [2:0]          wordsPerPt;
	logic [1:0]          selIdx;

	// ***************************************************************
	// Trigger and buffer memory
	// ***************************************************************
	scb_trig_sync u_trig (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.trigInN   (externalTriggerInputN),
		.fallPulse (trigFall)
	);

	scb_sample_mem #(.AW(AW), .DW(32)) u_mem (
		.clock   (clock),
		.sys_rst (sys_rst),
		.wrEn    (memWe),
		.wrAddr  (wrAddr_reg),
		.wrData  (memData),
		.rdAddr  (bufRdAddr),
		.rdData  (bufRdData)
	);

	// ***************************************************************
	// APB slave
	// ***************************************************************
	// Read mux and error decode
	always_comb begin
		addrOk = 1'b1;
		rdMux  = 32'h0;
		case (paddr)
			`SCB_OFS_CTRL:    rdMux = {27'h0, mode_reg, acq_reg, 2'h0};
			`SCB_OFS_LEN:     rdMux = {19'h0, lenKb_reg};
			`SCB_OFS_CFG:     rdMux = {30'h0, cfg_reg};
			`SCB_OFS_RATE:    rdMux = maxSampleRateHz >> rateExp_reg;
			`SCB_OFS_STAT:    rdMux = {29'h0, wrapped_reg, triggered_reg,
				inProg};
			`SCB_OFS_BYTES:   rdMux = {9'h0, byteCount_reg};
			`SCB_OFS_RATEMAX: rdMux = maxSampleRateHz;
			default:          addrOk = 1'b0;
		endcase
		slvErr = !addrOk || (pwrite && (paddr == `SCB_OFS_CTRL) &&
			pwdata[`SCB_CTRL_START] &&
			(pwdata[`SCB_CTRL_MODE_HI:`SCB_CTRL_MODE_LO] >
			`SCB_MODE_LAST));
	end

	assign apbSetup = psel && penable && !pready;
	assign apbOk    = psel && penable && pready && pwrite && !pslverr;

	// One wait state, answer registered
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apbSetup;
			pslverr <= apbSetup && slvErr;
			if (apbSetup) begin
				prdata <= (pwrite || slvErr) ? 32'h0 : rdMux;
			end
		end
	end

	// ***************************************************************
	// Command decode
	// ***************************************************************
	// Length clamp and round up, rate exponent clamp
	always_comb begin
		if (pwdata > {19'h0, `SCB_LEN_MAX}) begin
			lenClamp = `SCB_LEN_MAX;
		end else if (pwdata == 32'h0) begin
			lenClamp = 13'h0001;
		end else begin
			lenClamp = pwdata[12:0];
		end
		lenNew  = lenClamp + {12'h000, lenClamp[0]};
		rateNew = (pwdata > {27'h0, `SCB_RATE_EXP_MAX}) ?
			`SCB_RATE_EXP_MAX : pwdata[4:0];
	end

	assign startCmd = apbOk && (paddr == `SCB_OFS_CTRL) &&
		pwdata[`SCB_CTRL_START];
	assign stopCmd  = apbOk && (paddr == `SCB_OFS_CTRL) &&
		pwdata[`SCB_CTRL_STOP] && !pwdata[`SCB_CTRL_START];
	assign lenWr    = apbOk && (paddr == `SCB_OFS_LEN);
	assign cfgWr    = apbOk && (paddr == `SCB_OFS_CFG);
	assign cfgReset = (lenWr && (lenNew != lenKb_reg)) ||
		(cfgWr && (pwdata[1:0] != cfg_reg));

	// Configuration registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lenKb_reg   <= `SCB_LEN_RST;
			cfg_reg     <= `SCB_CFG_RST;
			rateExp_reg <= 5'h00;
			acq_reg     <= `SCB_ACQ_SINGLE;
			mode_reg    <= `SCB_MODE_IMMEDIATE;
		end else begin
			if (lenWr) begin
				lenKb_reg <= lenNew;
			end
			if (cfgWr) begin
				cfg_reg <= pwdata[1:0];
			end
			if (apbOk && (paddr == `SCB_OFS_RATE)) begin
				rateExp_reg <= rateNew;
			end
			if (startCmd) begin
				acq_reg  <= pwdata[`SCB_CTRL_ACQ];
				mode_reg <= pwdata[`SCB_CTRL_MODE_HI:`SCB_CTRL_MODE_LO];
			end
		end
	end

	// ***************************************************************
	// Rate divider and sample events
	// ***************************************************************
	assign divMask = 21'((22'h000001 << rateExp_reg) - 22'h000001);
	assign divTick = maxRateTick && (divCnt_reg == divMask);

	// Counts maximum-rate ticks, one sample per 2^n of them
	always_ff @(posedge clock) begin
		if (sys_rst || startCmd || cfgReset) begin
			divCnt_reg <= 21'h000000;
		end else if (maxRateTick) begin
			divCnt_reg <= divTick ? 21'h000000 : divCnt_reg + 21'h000001;
		end
	end

	assign sampleEvt   = (state_reg == scb_pkg::SCB_RUN) &&
		((mode_reg == `SCB_MODE_PER_EDGE) ? trigFall : divTick);
	assign trigStopEvt = (state_reg == scb_pkg::SCB_RUN) &&
		(acq_reg == `SCB_ACQ_WRAP) && (mode_reg == `SCB_MODE_EDGE) &&
		trigFall;
	assign stopReq     = stopPend_reg || trigStopEvt ||
		(stopCmd && (state_reg == scb_pkg::SCB_RUN));
	assign finishing   = (state_reg == scb_pkg::SCB_RUN) &&
		(wordsLeft_reg == 3'h0) && stopReq;
	assign accept      = sampleEvt && (wordsLeft_reg == 3'h0) && !stopReq;

	// ***************************************************************
	// Word sequencer
	// ***************************************************************
	assign smpIn[0] = sampleX;
	assign smpIn[1] = sampleY;
	assign smpIn[2] = sampleR;
	assign smpIn[3] = sampleTheta;

	// Words per point and word pick by channel set
	always_comb begin
		case (cfg_reg)
			2'h0:    wordsPerPt = 3'h1;
			2'h3:    wordsPerPt = 3'h4;
			default: wordsPerPt = 3'h2;
		endcase
		selIdx = (cfg_reg == 2'h2) ? subIdx_reg + 2'h2 : subIdx_reg;
	end

	assign memWe   = !startCmd && !cfgReset &&
		(((state_reg == scb_pkg::SCB_RUN) && (wordsLeft_reg != 3'h0)) ||
		(state_reg == scb_pkg::SCB_FILL));
	assign realWr  = memWe && (state_reg == scb_pkg::SCB_RUN);
	assign memData = (state_reg == scb_pkg::SCB_FILL) ? 32'h0 :
		smp_reg[selIdx];
	assign lastAddr = {lenKb_reg, 8'h00} - 21'h000001;
	assign atLast   = (wrAddr_reg == lastAddr[AW-1:0]);

	// Latches a point, then writes its words one per cycle
	always_ff @(posedge clock) begin
		if (sys_rst || startCmd || cfgReset ||
			(state_reg != scb_pkg::SCB_RUN)) begin
			wordsLeft_reg <= 3'h0;
			subIdx_reg    <= 2'h0;
		end else if (accept) begin
			wordsLeft_reg <= wordsPerPt;
			subIdx_reg    <= 2'h0;
		end else if (realWr) begin
			wordsLeft_reg <= wordsLeft_reg - 3'h1;
			subIdx_reg    <= subIdx_reg + 2'h1;
		end
	end

	// Sample word capture, all parameters at one instant
	for (genvar gi = 0; gi < 4; gi++) begin : g_smp
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				smp_reg[gi] <= 32'h0;
			end else if (accept) begin
				smp_reg[gi] <= smpIn[gi];
			end
		end
	end

	// ***************************************************************
	// Capture state machine
	// ***************************************************************
	always_ff @(posedge clock) begin
		if (sys_rst || cfgReset) begin
			state_reg <= scb_pkg::SCB_IDLE;
		end else if (startCmd) begin
			if ((pwdata[`SCB_CTRL_MODE_HI:`SCB_CTRL_MODE_LO] ==
				`SCB_MODE_EDGE) &&
				(pwdata[`SCB_CTRL_ACQ] == `SCB_ACQ_SINGLE)) begin
				state_reg <= scb_pkg::SCB_ARMED;
			end else begin
				state_reg <= scb_pkg::SCB_RUN;
			end
		end else begin
			case (state_reg)
				scb_pkg::SCB_ARMED: begin
					if (stopCmd) begin
						state_reg <= scb_pkg::SCB_IDLE;
					end else if (trigFall) begin
						state_reg <= scb_pkg::SCB_RUN;
					end
				end
				scb_pkg::SCB_RUN: begin
					if (realWr && atLast && (acq_reg == `SCB_ACQ_SINGLE)) begin
						state_reg <= scb_pkg::SCB_DONE;
					end else if (finishing) begin
						state_reg <= (wrAddr_reg[8:0] != 9'h000) ?
							scb_pkg::SCB_FILL : scb_pkg::SCB_DONE;
					end
				end
				scb_pkg::SCB_FILL: begin
					if (wrAddr_reg[8:0] == `SCB_BLOCK_LAST) begin
						state_reg <= scb_pkg::SCB_DONE;
					end
				end
				default: state_reg <= state_reg;
			endcase
		end
	end

	// Stop held until the point in flight is written
	always_ff @(posedge clock) begin
		if (sys_rst || cfgReset || startCmd ||
			(state_reg != scb_pkg::SCB_RUN)) begin
			stopPend_reg <= 1'b0;
		end else if (stopCmd || trigStopEvt) begin
			stopPend_reg <= 1'b1;
		end
	end

	// Write address and real byte count
	always_ff @(posedge clock) begin
		if (sys_rst || cfgReset || startCmd) begin
			wrAddr_reg    <= '0;
			byteCount_reg <= 23'h000000;
		end else if (memWe) begin
			wrAddr_reg <= atLast ? '0 :
				wrAddr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (realWr) begin
				byteCount_reg <= (wrapped_reg && (wrAddr_reg[8:0] == 9'h000)) ?
					byteCount_reg + `SCB_WORD_BYTES - `SCB_BLOCK_BYTES :
					byteCount_reg + `SCB_WORD_BYTES;
			end
		end
	end

	// Sticky triggered and wrapped flags
	always_ff @(posedge clock) begin
		if (sys_rst || cfgReset) begin
			triggered_reg <= 1'b0;
			wrapped_reg   <= 1'b0;
		end else if (startCmd) begin
			triggered_reg <= !((pwdata[`SCB_CTRL_MODE_HI:`SCB_CTRL_MODE_LO] ==
				`SCB_MODE_EDGE) && !pwdata[`SCB_CTRL_ACQ]);
			wrapped_reg   <= 1'b0;
		end else begin
			if ((state_reg == scb_pkg::SCB_ARMED) && trigFall && !stopCmd) begin
				triggered_reg <= 1'b1;
			end
			if (memWe && atLast) begin
				wrapped_reg <= 1'b1;
			end
		end
	end

	assign inProg = (state_reg == scb_pkg::SCB_RUN) ||
		(state_reg == scb_pkg::SCB_FILL);

	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_lastReal;
		realWr && atLast;
	endsequence

	a_single_pass_stop: assert property (s_lastReal ##0 !acq_reg |=>
		state_reg == scb_pkg::SCB_DONE && !inProg && wrapped_reg)
		else $error("single pass did not stop at buffer end");
	a_wrap_rollover: assert property (s_lastReal ##0 acq_reg |=>
		wrAddr_reg == '0 && wrapped_reg && state_reg == scb_pkg::SCB_RUN)
		else $error("wrapping capture did not roll over");
	a_fill_zeros: assert property (state_reg == scb_pkg::SCB_FILL &&
		!cfgReset && !startCmd |-> memWe && memData == 32'h0)
		else $error("zero fill missing");
	a_fill_block_end: assert property (state_reg == scb_pkg::SCB_FILL &&
		wrAddr_reg[8:0] == `SCB_BLOCK_LAST && !cfgReset && !startCmd
		|=> state_reg == scb_pkg::SCB_DONE && wrAddr_reg[8:0] == 9'h000)
		else $error("zero fill overran the block");
	a_byte_step: assert property (realWr && !wrapped_reg && !cfgReset
		|=> byteCount_reg == $past(byteCount_reg) + `SCB_WORD_BYTES)
		else $error("byte count did not step by four");
	a_start_fresh: assert property (startCmd && !cfgReset |=>
		wrAddr_reg == '0 && byteCount_reg == 23'h0 && !wrapped_reg)
		else $error("start did not discard old capture");
	a_armed_abort: assert property (state_reg == scb_pkg::SCB_ARMED &&
		stopCmd && !cfgReset |=> state_reg == scb_pkg::SCB_IDLE ##1
		!triggered_reg)
		else $error("stop did not abort an armed capture");
	a_done_inert: assert property (state_reg == scb_pkg::SCB_DONE &&
		stopCmd |=> $stable(byteCount_reg) && $stable(wrAddr_reg) &&
		state_reg == scb_pkg::SCB_DONE)
		else $error("stop after end disturbed the capture");
	a_edge_start: assert property (state_reg == scb_pkg::SCB_ARMED &&
		trigFall && !stopCmd && !startCmd && !cfgReset |=>
		state_reg == scb_pkg::SCB_RUN && triggered_reg)
		else $error("falling edge did not start capture");
	a_len_even: assert property (lenKb_reg[0] == 1'b0 &&
		lenKb_reg != 13'h0 && lenKb_reg <= `SCB_LEN_MAX)
		else $error("buffer length out of range or odd");
	a_trig_pulse: assert property (trigFall |=> !trigFall)
		else $error("trigger pulse longer than one cycle");
endmodule

// ===== tb/scb_far_side.sv
/*
 Far side model: maximum-rate tick, sample words and trigger pin.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module scb_far_side #(
	parameter logic [31:0] RATE_HZ = 32'h0001312D
) (
	input  wire logic        clock,
	output logic             maxRateTick,
	output logic      [31:0] maxSampleRateHz,
	output logic      [31:0] sampleX,
	output logic      [31:0] sampleY,
	output logic      [31:0] sampleR,
	output logic      [31:0] sampleTheta,
	output logic             trigN
);
	logic [15:0] cnt = 16'h0000;
	// Tick on every second cycle, nonzero words that change
	always @(posedge clock) begin
		cnt         <= cnt + 16'h0001;
		maxRateTick <= cnt[0];
	end
	assign maxSampleRateHz = RATE_HZ;
	assign sampleX         = {16'h3F80, cnt};
	assign sampleY         = {16'h4000, cnt};
	assign sampleR         = {16'h4040, cnt};
	assign sampleTheta     = {16'h4080, cnt};
	initial trigN = 1'b1;
	// Edges kept slower than one full capture point
	task automatic pulse();
		trigN <= 1'b0;
		repeat (8) @(posedge clock);
		trigN <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	// Pin held at a level, pull-up idle is high
	task automatic level(input logic v);
		trigN <= v;
	endtask
endmodule

// ===== tb/test_sample_capture_buffer_control.sv
/*
 Self-checking bench of the capture control, driven over APB.
 Assumes the far side model supplies tick, samples and trigger.
*/
`timescale 1ns/1ps
`include "scb_consts.svh"
module test_sample_capture_buffer_control;
	localparam logic [31:0] HZ = 32'h0001312D;
	logic        clock     = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h00000000;
	logic [11:0] bufRdAddr = 12'h000;
	logic [31:0] prdata, q, sx, sy, sr, st, bufRdData, rateHz;
	logic        pready, pslverr, err, tick, trigN;
	int          n_fail    = 0;
	int          n_tests   = 0;
	int          cyc       = 0;

	scb_capture_ctrl #(.AW(12)) scb_capture_ctrl_i (.clock(clock),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .maxRateTick(tick), .maxSampleRateHz(rateHz),
		.sampleX(sx), .sampleY(sy), .sampleR(sr), .sampleTheta(st),
		.externalTriggerInputN(trigN), .bufRdAddr(bufRdAddr),
		.bufRdData(bufRdData));
	scb_far_side #(.RATE_HZ(HZ)) far (.clock(clock), .maxRateTick(tick),
		.maxSampleRateHz(rateHz), .sampleX(sx), .sampleY(sy),
		.sampleR(sr), .sampleTheta(st), .trigN(trigN));

	always #5 clock = ~clock;
	// Hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic results();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic waitIdle();
		do
			xfer(1'b0, `SCB_OFS_STAT, 32'h0);
		while (q[0] !== 1'b0);
	endtask
	// Buffer word read through the registered port, masked compare
	task automatic bufChk(input logic [11:0] a, input logic [31:0] m,
			input logic [31:0] e);
		bufRdAddr <= a;
		repeat (2) @(posedge clock);
		chk(bufRdData & m, e);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(`SCB_OFS_LEN, 32'h20);
		rd(`SCB_OFS_STAT, 32'h0);
		rd(`SCB_OFS_RATEMAX, HZ);
		xfer(1'b1, 8'h1C, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b1, `SCB_OFS_LEN, 32'h3);
		rd(`SCB_OFS_LEN, 32'h4);
		xfer(1'b1, `SCB_OFS_LEN, 32'h1388);
		rd(`SCB_OFS_LEN, 32'h1000);
		xfer(1'b1, `SCB_OFS_LEN, 32'h2);
		xfer(1'b1, `SCB_OFS_RATE, 32'h19);
		rd(`SCB_OFS_RATE, HZ >> 20);
		xfer(1'b1, `SCB_OFS_RATE, 32'h0);
		rd(`SCB_OFS_RATE, HZ);
		// Single pass, immediate; then a stop after the end
		xfer(1'b1, `SCB_OFS_CTRL, 32'h01);
		waitIdle();
		rd(`SCB_OFS_BYTES, 32'h800);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h02);
		rd(`SCB_OFS_BYTES, 32'h800);
		rd(`SCB_OFS_STAT, 32'h6);
		// Wrapping, immediate, stopped mid-block after a rollover
		xfer(1'b1, `SCB_OFS_CTRL, 32'h05);
		repeat (1300) @(posedge clock);
		rd(`SCB_OFS_STAT, 32'h7);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h02);
		waitIdle();
		xfer(1'b0, `SCB_OFS_BYTES, 32'h0);
		chk({30'h0, q[1:0]}, 32'h0);
		bufChk(q[13:2], 32'hFFFFFFFF, 32'h0);
		rd(`SCB_OFS_STAT, 32'h6);
		xfer(1'b1, `SCB_OFS_CFG, 32'h3);
		rd(`SCB_OFS_STAT, 32'h0);
		// One sample per edge, divider at its slowest
		xfer(1'b1, `SCB_OFS_RATE, 32'h14);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h11);
		rd(`SCB_OFS_BYTES, 32'h0);
		repeat (3) far.pulse();
		rd(`SCB_OFS_BYTES, 32'h30);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h02);
		waitIdle();
		rd(`SCB_OFS_BYTES, 32'h30);
		bufChk(12'h00C, 32'hFFFFFFFF, 32'h0);
		bufChk(12'h001, 32'hFFFF0000, 32'h40000000);
		bufChk(12'h003, 32'hFFFF0000, 32'h40800000);
		xfer(1'b1, `SCB_OFS_RATE, 32'h0);
		// Single pass edge start; a rising edge must not start it
		far.level(1'b0);
		// Let the falling edge pass the synchroniser before arming
		repeat (6) @(posedge clock);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h09);
		far.level(1'b1);
		repeat (10) @(posedge clock);
		rd(`SCB_OFS_STAT, 32'h0);
		// First edge starts, second edge must not stop
		far.pulse();
		far.pulse();
		rd(`SCB_OFS_STAT, 32'h3);
		waitIdle();
		rd(`SCB_OFS_BYTES, 32'h800);
		rd(`SCB_OFS_STAT, 32'h6);
		// Stop while armed, later edge ignored
		xfer(1'b1, `SCB_OFS_CTRL, 32'h09);
		rd(`SCB_OFS_BYTES, 32'h0);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h02);
		far.pulse();
		rd(`SCB_OFS_STAT, 32'h0);
		// Wrapping, edge ends the capture
		xfer(1'b1, `SCB_OFS_CTRL, 32'h0D);
		repeat (50) @(posedge clock);
		far.pulse();
		waitIdle();
		// Zero fill runs to the end of the one-block buffer: wrapped set
		rd(`SCB_OFS_STAT, 32'h6);
		xfer(1'b1, `SCB_OFS_CTRL, 32'h19);
		chk({31'h0, err}, 32'h1);
		rd(`SCB_OFS_STAT, 32'h6);
		results();
	end
endmodule
